//--- tm2_consts.vh
// register map, field positions and reset values of the reload/compare timer
`ifndef TM2_CONSTS_VH
`define TM2_CONSTS_VH

// register indices; byte address is four times the index
`define TM2_IDX_CONTROL 8'hc8
`define TM2_IDX_MODE 8'hc9
`define TM2_IDX_RCMP_LOW 8'hca
`define TM2_IDX_RCMP_HIGH 8'hcb
`define TM2_IDX_COUNT_LOW 8'hcc
`define TM2_IDX_COUNT_HIGH 8'hcd
`define TM2_IDX_IRQ_ENABLE 8'hd1

// control register fields
`define TM2_CTL_OVERFLOW_FLAG 7
`define TM2_CTL_RUN_CONTROL 2
`define TM2_CTL_COMPARE_SELECT 0

// mode register fields
`define TM2_MOD_RELOAD_ENABLE 7
`define TM2_MOD_DIV_HI 6
`define TM2_MOD_DIV_LO 4
`define TM2_MOD_CAPTURE_CLEAR 3
`define TM2_MOD_MATCH_CLEAR 2
`define TM2_MOD_TRIG_HI 1
`define TM2_MOD_TRIG_LO 0

// interrupt enable register fields
`define TM2_IEN_TIMER 0
`define TM2_IEN_GLOBAL 1

// reset values
`define TM2_RST_CONTROL 8'h00
`define TM2_RST_MODE 8'h00
`define TM2_RST_BYTE 8'h00
`define TM2_RST_IEN 2'h0

// reload trigger codes
`define TM2_TRIG_OVERFLOW 2'h0

// prescaler terminal counts (divide ratio minus one)
`define TM2_DIV_1 9'h000
`define TM2_DIV_4 9'h003
`define TM2_DIV_16 9'h00f
`define TM2_DIV_32 9'h01f
`define TM2_DIV_64 9'h03f
`define TM2_DIV_128 9'h07f
`define TM2_DIV_256 9'h0ff
`define TM2_DIV_512 9'h1ff

// bus responses
`define TM2_RESP_OKAY 2'h0
`define TM2_RESP_SLVERR 2'h2

`endif

//--- tm2_prescaler.v
// clock prescaler producing the timer counting enable
`timescale 1ns/1ps
`include "tm2_consts.vh"

module tm2_prescaler
(
   input wire clk_i,
   input wire rst_i,
   input wire run_i,
   input wire [2:0] sel_i,
   output wire tick_o
);

   reg [8:0] cnt;
   reg [8:0] limit;

   always @*
   begin
      case (sel_i)
         3'h0: limit = `TM2_DIV_1;
         3'h1: limit = `TM2_DIV_4;
         3'h2: limit = `TM2_DIV_16;
         3'h3: limit = `TM2_DIV_32;
         3'h4: limit = `TM2_DIV_64;
         3'h5: limit = `TM2_DIV_128;
         3'h6: limit = `TM2_DIV_256;
         3'h7: limit = `TM2_DIV_512;
         default: limit = `TM2_DIV_1;
      endcase
   end

   // >= keeps a shrinking ratio from wrapping the full 512 range
   always @(posedge clk_i)
   begin
      if (rst_i || !run_i)
      begin
         cnt <= 9'h000;
      end
      else if (cnt >= limit)
      begin
         cnt <= 9'h000;
      end
      else
      begin
         cnt <= cnt + 9'h001;
      end
   end

   assign tick_o = run_i && (cnt >= limit);

endmodule // tm2_prescaler

//--- tm2_timer.v
// 16-bit reload/compare/capture timer with AXI4-Lite register access
//
// How it works
// - flag sets on counter overflow and on compare match in compare mode.
// - interrupt request is flag and timer enable and global enable.
// - run bit 0 freezes the count; 1 lets it count.
// - mode bit 0 is auto-reload, 1 is compare.
// - reload enable 1 loads reload bytes into counter on each trigger, unless a capture auto-clear zeroes it in that cycle.
// - divider codes 0..7 divide by 1,4,16,32,64,128,256,512.
// - capture in auto-reload mode copies count into reload bytes.
// - capture auto-clear zeroes counter after the capture copy.
// - capture auto-clear only acts in auto-reload mode.
// - match auto-clear zeroes counter after a match, compare mode only.
// - trigger select 0 overflow, 1..3 capture channels 0..2.
// - reload bytes are compare value or reload value by mode.
// - counter is high and low byte, both software read/write.
`timescale 1ns/1ps
`include "tm2_consts.vh"

module tm2_timer
(
   input wire MCLK_I,
   input wire RST_I,
   input wire [11:0] AXI_AWADDR_I,
   input wire AXI_AWVALID_I,
   output wire AXI_AWREADY_O,
   input wire [31:0] AXI_WDATA_I,
   input wire [3:0] AXI_WSTRB_I,
   input wire AXI_WVALID_I,
   output wire AXI_WREADY_O,
   output wire [1:0] AXI_BRESP_O,
   output wire AXI_BVALID_O,
   input wire AXI_BREADY_I,
   input wire [11:0] AXI_ARADDR_I,
   input wire AXI_ARVALID_I,
   output wire AXI_ARREADY_O,
   output wire [31:0] AXI_RDATA_O,
   output wire [1:0] AXI_RRESP_O,
   output wire AXI_RVALID_O,
   input wire AXI_RREADY_I,
   input wire [2:0] CAP_EVT_I,
   output wire TMR_FLAG_O,
   output wire TMR_IRQ_O
);

   // register state
   reg overflow_flag;
   reg run_control;
   reg compare_or_reload_select;
   reg [7:0] mode;
   reg [7:0] reload_compare_low;
   reg [7:0] reload_compare_high;
   reg [7:0] count_low;
   reg [7:0] count_high;
   reg [1:0] irq_enable;

   // write channel holding state
   reg aw_full;
   reg w_full;
   reg [9:0] aw_word;
   reg [7:0] w_byte;
   reg w_lane0;
   reg bvalid;
   reg [1:0] bresp;

   // read channel state
   reg rvalid;
   reg [1:0] rresp;
   reg [31:0] rdata;

   // mode fields
   // mode has no reserved bits, so it reads back exactly as written
   wire reload_enable = mode[`TM2_MOD_RELOAD_ENABLE];
   wire [2:0] clock_divider_sel = mode[`TM2_MOD_DIV_HI:`TM2_MOD_DIV_LO];
   wire capture_auto_clear = mode[`TM2_MOD_CAPTURE_CLEAR];
   wire match_auto_clear = mode[`TM2_MOD_MATCH_CLEAR];
   wire [1:0] reload_trigger_sel = mode[`TM2_MOD_TRIG_HI:`TM2_MOD_TRIG_LO];

   wire [15:0] count = {count_high, count_low};
   wire [15:0] reload_value = {reload_compare_high, reload_compare_low};
   wire tick;

   // prescaler restarts from zero whenever the run bit is clear
   tm2_prescaler tm2_prescaler_i
   (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .run_i (run_control),
      .sel_i (clock_divider_sel),
      .tick_o (tick)
   );

   // write decode: address and data are taken in either order
   wire do_write = aw_full && w_full && !bvalid;
   wire aw_hi_zero = (aw_word[9:8] == 2'h0);
   wire [7:0] aw_idx = aw_word[7:0];
   wire wr_en = do_write && w_lane0 && aw_hi_zero;

   wire wr_ctl = wr_en && (aw_idx == `TM2_IDX_CONTROL);
   wire wr_mod = wr_en && (aw_idx == `TM2_IDX_MODE);
   wire wr_rcl = wr_en && (aw_idx == `TM2_IDX_RCMP_LOW);
   wire wr_rch = wr_en && (aw_idx == `TM2_IDX_RCMP_HIGH);
   wire wr_cl = wr_en && (aw_idx == `TM2_IDX_COUNT_LOW);
   wire wr_ch = wr_en && (aw_idx == `TM2_IDX_COUNT_HIGH);
   wire wr_ien = wr_en && (aw_idx == `TM2_IDX_IRQ_ENABLE);

   // unmapped words answer with an error and change nothing
   function mapped;
      input [9:0] word;
      begin
         mapped = 1'b0;
         if (word[9:8] == 2'h0)
         begin
            case (word[7:0])
               `TM2_IDX_CONTROL,
               `TM2_IDX_MODE,
               `TM2_IDX_RCMP_LOW,
               `TM2_IDX_RCMP_HIGH,
               `TM2_IDX_COUNT_LOW,
               `TM2_IDX_COUNT_HIGH,
               `TM2_IDX_IRQ_ENABLE: mapped = 1'b1;
               default: mapped = 1'b0;
            endcase
         end
      end
   endfunction

   // counting, reload, compare and capture
   reg [15:0] next_count;
   reg [15:0] next_reload;
   reg overflow;
   reg match;
   reg trigger;
   reg capture;

   always @*
   begin
      next_count = count;
      next_reload = reload_value;
      overflow = 1'b0;
      match = 1'b0;
      capture = 1'b0;
      trigger = 1'b0;
      // count only advances on an enabled tick
      if (tick)
      begin
         overflow = (count == 16'hffff);
         match = compare_or_reload_select && (count == reload_value);
         next_count = count + 16'h0001;
         // a match clear still yields to a reload or a capture clear
         if (match && match_auto_clear)
         begin
            next_count = 16'h0000;
         end
      end
      case (reload_trigger_sel)
         `TM2_TRIG_OVERFLOW: trigger = overflow;
         2'h1: trigger = CAP_EVT_I[0];
         2'h2: trigger = CAP_EVT_I[1];
         2'h3: trigger = CAP_EVT_I[2];
         default: trigger = overflow;
      endcase
      // reload uses the value held before any capture this cycle
      if (reload_enable && trigger)
      begin
         next_count = reload_value;
      end
      // compare mode takes no capture copy; a capture event can still trigger a reload
      capture = !compare_or_reload_select && (|CAP_EVT_I);
      if (capture)
      begin
         next_reload = count;
         if (capture_auto_clear)
         begin
            next_count = 16'h0000;
         end
      end
   end

   wire set_flag = overflow || match;

   // control register and flag
   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         overflow_flag <= 1'b0;
         run_control <= 1'b0;
         compare_or_reload_select <= 1'b0;
         mode <= `TM2_RST_MODE;
         irq_enable <= `TM2_RST_IEN;
      end
      else
      begin
         // a hardware set in the clearing cycle is never lost
         if (set_flag)
         begin
            overflow_flag <= 1'b1;
         end
         // software may also write one, which lets it test the interrupt path
         else if (wr_ctl)
         begin
            overflow_flag <= w_byte[`TM2_CTL_OVERFLOW_FLAG];
         end
         if (wr_ctl)
         begin
            run_control <= w_byte[`TM2_CTL_RUN_CONTROL];
            compare_or_reload_select <= w_byte[`TM2_CTL_COMPARE_SELECT];
         end
         if (wr_mod)
         begin
            mode <= w_byte;
         end
         if (wr_ien)
         begin
            irq_enable <= w_byte[1:0];
         end
      end
   end

   // counter and reload/compare bytes; software writes win per byte
   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         count_low <= `TM2_RST_BYTE;
         count_high <= `TM2_RST_BYTE;
         reload_compare_low <= `TM2_RST_BYTE;
         reload_compare_high <= `TM2_RST_BYTE;
      end
      else
      begin
         count_low <= wr_cl ? w_byte : next_count[7:0];
         count_high <= wr_ch ? w_byte : next_count[15:8];
         reload_compare_low <= wr_rcl ? w_byte : next_reload[7:0];
         reload_compare_high <= wr_rch ? w_byte : next_reload[15:8];
      end
   end

   // write address and data channels, response after both
   // a write lands on the edge after both halves are held
   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_word <= 10'h000;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `TM2_RESP_OKAY;
      end
      else
      begin
         if (AXI_AWVALID_I && AXI_AWREADY_O)
         begin
            aw_full <= 1'b1;
            aw_word <= AXI_AWADDR_I[11:2];
         end
         if (AXI_WVALID_I && AXI_WREADY_O)
         begin
            w_full <= 1'b1;
            w_byte <= AXI_WDATA_I[7:0];
            w_lane0 <= AXI_WSTRB_I[0];
         end
         if (do_write)
         begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            bvalid <= 1'b1;
            bresp <= mapped(aw_word) ? `TM2_RESP_OKAY : `TM2_RESP_SLVERR;
         end
         else if (bvalid && AXI_BREADY_I)
         begin
            bvalid <= 1'b0;
         end
      end
   end

   // read mux; unwritten upper bits read as zero
   reg [7:0] rd_byte;
   wire [9:0] ar_word = AXI_ARADDR_I[11:2];

   always @*
   begin
      rd_byte = 8'h00;
      if (ar_word[9:8] == 2'h0)
      begin
         case (ar_word[7:0])
            `TM2_IDX_CONTROL: rd_byte = {overflow_flag, 4'h0, run_control,
                                         1'b0, compare_or_reload_select};
            `TM2_IDX_MODE: rd_byte = mode;
            `TM2_IDX_RCMP_LOW: rd_byte = reload_compare_low;
            `TM2_IDX_RCMP_HIGH: rd_byte = reload_compare_high;
            `TM2_IDX_COUNT_LOW: rd_byte = count_low;
            `TM2_IDX_COUNT_HIGH: rd_byte = count_high;
            `TM2_IDX_IRQ_ENABLE: rd_byte = {6'h00, irq_enable};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   always @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         rvalid <= 1'b0;
         rresp <= `TM2_RESP_OKAY;
         rdata <= 32'h00000000;
      end
      // data are frozen when the address is taken; a running count moves on
      else if (AXI_ARVALID_I && AXI_ARREADY_O)
      begin
         rvalid <= 1'b1;
         rdata <= {24'h000000, rd_byte};
         rresp <= mapped(ar_word) ? `TM2_RESP_OKAY : `TM2_RESP_SLVERR;
      end
      else if (rvalid && AXI_RREADY_I)
      begin
         rvalid <= 1'b0;
      end
   end

   // no new write is taken while a response is pending
   assign AXI_AWREADY_O = !aw_full && !bvalid;
   assign AXI_WREADY_O = !w_full && !bvalid;
   assign AXI_BVALID_O = bvalid;
   assign AXI_BRESP_O = bresp;
   assign AXI_ARREADY_O = !rvalid;
   assign AXI_RVALID_O = rvalid;
   assign AXI_RDATA_O = rdata;
   assign AXI_RRESP_O = rresp;

   assign TMR_FLAG_O = overflow_flag;
   assign TMR_IRQ_O = overflow_flag && irq_enable[`TM2_IEN_TIMER]
                      && irq_enable[`TM2_IEN_GLOBAL];

endmodule // tm2_timer

//--- tm2_timer_assertions.sv
// port checker of the reload/compare timer
`timescale 1ns/1ps
module tm2_timer_checker
(
   input logic MCLK_I,
   input logic RST_I,
   input logic AXI_AWREADY_O,
   input logic AXI_WREADY_O,
   input logic AXI_BVALID_O,
   input logic AXI_ARVALID_I,
   input logic AXI_ARREADY_O,
   input logic [31:0] AXI_RDATA_O,
   input logic [1:0] AXI_RRESP_O,
   input logic AXI_RVALID_O,
   input logic TMR_FLAG_O,
   input logic TMR_IRQ_O
);
   default clocking
      @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);
   AST_IRQ_NEEDS_FLAG:
      assert property (TMR_IRQ_O |-> TMR_FLAG_O) else $error("irq without flag");
   // guard: a short reset may drop the flag without a write
   AST_FLAG_SW_CLEAR:
      assert property ($fell(TMR_FLAG_O) && !$past(RST_I) |-> $rose(AXI_BVALID_O))
      else $error("flag fell without write");
   AST_READ_ONE_CYCLE:
      assert property (AXI_ARVALID_I && AXI_ARREADY_O |=> AXI_RVALID_O)
      else $error("read answer late");
   AST_NO_AR_WHILE_R:
      assert property (AXI_RVALID_O |-> !AXI_ARREADY_O) else $error("ar open");
   AST_RDATA_UPPER_ZERO:
      assert property (AXI_RVALID_O |-> AXI_RDATA_O[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_ERR_READS_ZERO:
      assert property (AXI_RVALID_O && AXI_RRESP_O == 2'h2 |-> AXI_RDATA_O == 32'h0)
      else $error("error read data");
   AST_NO_WRITE_WHILE_B:
      assert property (AXI_BVALID_O |-> !AXI_AWREADY_O && !AXI_WREADY_O)
      else $error("write open during response");
   AST_B_AFTER_TAKE:
      assert property ($rose(AXI_BVALID_O) |-> !$past(AXI_AWREADY_O) && !$past(AXI_WREADY_O))
      else $error("response without write");
endmodule // tm2_timer_checker

//--- tm2_tb.sv
// self-checking bench of the reload/compare timer
`timescale 1ns/1ps
module tb;
   logic mclk, rst, awv, wv, bready, arv, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [2:0] cap;
   wire awready, wready, bvalid, arready, rvalid, flag, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer n_fail = 0;
   integer n_checks = 0;
   integer i, k, sel;
   integer divs [8] = '{1, 4, 16, 32, 64, 128, 256, 512};
   logic [7:0] regs [7] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd1};
   logic [15:0] t_rc [5] = '{16'h0010, 16'h0010, 16'hfff0, 16'hfff0, 16'h0010};
   logic [15:0] t_cn [5] = '{16'h0000, 16'h0000, 16'hfffe, 16'hfffe, 16'h0000};
   logic [7:0] t_md [5] = '{8'h04, 8'h00, 8'h80, 8'h00, 8'h04};
   logic [7:0] t_ct [5] = '{8'h05, 8'h05, 8'h04, 8'h04, 8'h04};
   integer t_k [5] = '{17, 17, 2, 2, 0};
   logic t_s [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
   tm2_timer tm2_timer_i
   (
      .MCLK_I(mclk), .RST_I(rst), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awv),
      .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(4'h1),
      .AXI_WVALID_I(wv), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
      .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
      .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata),
      .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
      .CAP_EVT_I(cap), .TMR_FLAG_O(flag), .TMR_IRQ_O(irq)
   );
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task end_sim;
   begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
   begin
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   task tmo;
   begin
      cmp("wait limit", 32'h0, 32'h1);
      end_sim;
   end
   endtask
   // response code 3 never comes back, so it marks a missing answer
   task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      integer j;
      logic [1:0] r;
   begin
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      r = 2'h3;
      for (j = 0; j < 60 && r === 2'h3; j++)
      begin
         @(posedge mclk);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
         if (bvalid) r = bresp;
      end
      // bready stays high between writes, never lowered and raised in one step
      if (r === 2'h3) tmo;
      cmp("bresp", {30'h0, er}, {30'h0, r});
   end
   endtask
   task rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
      integer j;
      logic [1:0] r;
   begin
      araddr <= {2'h0, idx, 2'h0};
      arv <= 1'b1;
      rready <= 1'b1;
      r = 2'h3;
      for (j = 0; j < 60 && r === 2'h3; j++)
      begin
         @(posedge mclk);
         if (arready) arv <= 1'b0;
         if (rvalid) r = rresp;
      end
      if (r === 2'h3) tmo;
      cmp("rdata", {24'h0, e}, rdata);
      cmp("rresp", {30'h0, er}, {30'h0, r});
   end
   endtask
   task wflag(input integer m, output integer n);
   begin
      n = 0;
      while (n < m && flag !== 1'b1)
      begin
         @(posedge mclk);
         n++;
      end
   end
   endtask
   // stopped timer, so every count read back is exact
   task capt(input logic [7:0] ct, input logic [7:0] md, input integer ch,
      input logic [15:0] ec, input logic [15:0] ev);
   begin
      wr(8'hc8, ct, 2'h0);
      wr(8'hca, 8'hcd, 2'h0);
      wr(8'hcb, 8'hab, 2'h0);
      wr(8'hcc, 8'h11, 2'h0);
      wr(8'hcd, 8'h00, 2'h0);
      wr(8'hc9, md, 2'h0);
      cap <= 3'h1 << ch;
      @(posedge mclk);
      cap <= 3'h0;
      @(posedge mclk);
      rd(8'hcc, ec[7:0], 2'h0);
      rd(8'hcd, ec[15:8], 2'h0);
      rd(8'hca, ev[7:0], 2'h0);
      rd(8'hcb, ev[15:8], 2'h0);
   end
   endtask
   initial
   begin
      rst <= 1'b1;
      {awv, wv, bready, arv, rready} <= 5'h0;
      awaddr <= 12'h0;
      araddr <= 12'h0;
      wdata <= 32'h0;
      cap <= 3'h0;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      foreach (regs[j])
         rd(regs[j], 8'h00, 2'h0);
      rd(8'he0, 8'h00, 2'h2);
      wr(8'he0, 8'hff, 2'h2);
      $display("test reset and map done");
      wr(8'hc8, 8'h80, 2'h0);
      cmp("flag", 32'h1, {31'h0, flag});
      for (i = 0; i < 3; i++)
      begin
         wr(8'hd1, i[7:0] + 8'h01, 2'h0);
         cmp("irq", (i == 2) ? 32'h1 : 32'h0, {31'h0, irq});
      end
      wr(8'hd1, 8'h00, 2'h0);
      wr(8'hc8, 8'h00, 2'h0);
      cmp("flag", 32'h0, {31'h0, flag});
      $display("test interrupt done");
      for (i = 0; i < 8; i++)
      begin
         wr(8'hc8, 8'h00, 2'h0);
         wr(8'hcc, 8'hff, 2'h0);
         wr(8'hcd, 8'hff, 2'h0);
         wr(8'hc9, {1'b0, i[2:0], 4'h0}, 2'h0);
         wr(8'hc8, 8'h04, 2'h0);
         wflag(600, k);
         if (flag !== 1'b1) tmo;
         cmp("ticks", divs[i], k);
      end
      repeat (20) @(posedge mclk);
      cmp("flag", 32'h1, {31'h0, flag});
      rd(8'hcd, 8'h00, 2'h0);
      $display("test divider done");
      for (i = 0; i < 5; i++)
      begin
         wr(8'hc8, 8'h00, 2'h0);
         wr(8'hca, t_rc[i][7:0], 2'h0);
         wr(8'hcb, t_rc[i][15:8], 2'h0);
         wr(8'hcc, t_cn[i][7:0], 2'h0);
         wr(8'hcd, t_cn[i][15:8], 2'h0);
         wr(8'hc9, t_md[i], 2'h0);
         wr(8'hc8, t_ct[i], 2'h0);
         wflag(40, k);
         if (t_k[i] != 0 && flag !== 1'b1) tmo;
         cmp("first event", t_k[i], (flag === 1'b1) ? k : 0);
         wr(8'hc8, t_ct[i], 2'h0);
         wflag(40, k);
         cmp("second event", {31'h0, t_s[i]}, {31'h0, flag});
      end
      $display("test compare and reload done");
      for (i = 0; i < 9; i++)
      begin
         sel = i / 3 + 1;
         capt(8'h00, 8'h80 | sel[7:0], i % 3,
            (i % 3 == sel - 1) ? 16'habcd : 16'h0011, 16'h0011);
      end
      capt(8'h00, 8'h08, 1, 16'h0000, 16'h0011);
      capt(8'h01, 8'h08, 1, 16'h0011, 16'habcd);
      $display("test capture done");
      end_sim;
   end
endmodule // tb
bind tm2_timer tm2_timer_checker tm2_timer_checker_i
(
   .MCLK_I(MCLK_I), .RST_I(RST_I), .AXI_AWREADY_O(AXI_AWREADY_O),
   .AXI_WREADY_O(AXI_WREADY_O), .AXI_BVALID_O(AXI_BVALID_O),
   .AXI_ARVALID_I(AXI_ARVALID_I), .AXI_ARREADY_O(AXI_ARREADY_O),
   .AXI_RDATA_O(AXI_RDATA_O), .AXI_RRESP_O(AXI_RRESP_O), .AXI_RVALID_O(AXI_RVALID_O),
   .TMR_FLAG_O(TMR_FLAG_O), .TMR_IRQ_O(TMR_IRQ_O)
);
